// ---- src/led_map.svh ----
// constants for the status indicator driver: timing, register offsets, fields
// assumes a 20 MHz core clock and a 32-bit AHB-Lite register window
`ifndef LED_MAP_SVH
`define LED_MAP_SVH

// clock and time base
`define CLK_HZ 20000000
`define MS_PER_S 1000
`define FLASH_MS 200
`define LONG_OFF_MS 1000
// 200 ms steps per single and double flash cycle
`define SINGLE_STEPS (1 + `LONG_OFF_MS / `FLASH_MS)
`define DOUBLE_STEPS (3 + `LONG_OFF_MS / `FLASH_MS)
`define STEP_W 4
`define STEP_MS_W 8

// register byte offsets
`define ADDR_MODE 8'h00
`define ADDR_FBUS 8'h04
`define ADDR_INPUTS 8'h08
`define ADDR_OUTPUTS 8'h0C
`define ADDR_STATUS 8'h10

// writable bits, reserved bits read zero
`define MODE_MASK 32'h0000_0033
`define FBUS_MASK 32'h0000_0033
`define INPUTS_MASK 32'h0000_FFFF
`define OUTPUTS_MASK 32'h0000_FFFF
`define REG_RST 32'h0000_0000

// field positions
`define MODE_PHASE_MSB 1
`define MODE_PHASE_LSB 0
`define MODE_PC_BIT 4
`define MODE_EXT_BIT 5
`define FBUS_RUN_MSB 1
`define FBUS_RUN_LSB 0
`define FBUS_ERR_MSB 5
`define FBUS_ERR_LSB 4
`define IN_COND_LSB 0
`define IN_FAULT_LSB 8
`define OUT_CFG_LSB 8
`define OUT_AUX_LSB 12

`define N_INPUTS 8
`define N_OUTPUTS 4
`endif

// ---- src/led_pkg.sv ----
// types shared by the status indicator driver and its pattern generator
// assumes led_map.svh is on the include path
`include "led_map.svh"
package led_pkg;
   typedef enum logic [1:0] {PH_TEST, PH_FW_LOAD, PH_OPERATE} phase_e;
   typedef enum logic [1:0] {FB_INIT, FB_PREOP, FB_SAFEOP, FB_OP} fb_state_e;
   typedef enum logic [1:0] {ERR_NONE, ERR_CONFIG, ERR_LOCAL, ERR_WDOG} fb_err_e;
   typedef enum logic [1:0] {SO_OFF, SO_ON, SO_RESTART, SO_FBK_BAD} so_state_e;
   typedef enum logic [2:0] {
      SEL_MODE, SEL_FBUS, SEL_INPUTS, SEL_OUTPUTS, SEL_STATUS, SEL_NONE
   } reg_sel_e;

   typedef struct packed {
      logic blink;
      logic single;
      logic dbl;
   } pattern_s;

   typedef struct packed {
      logic run_indicator;
      logic input_fail_indicator;
      logic external_fault_indicator;
      logic com_indicator;
      logic enable_indicator;
      logic [`N_INPUTS-1:0] input_indicators;
      logic [`N_OUTPUTS-1:0] safety_output_red;
      logic [`N_OUTPUTS-1:0] safety_output_green;
      logic [`N_OUTPUTS-1:0] aux_signal_indicators;
      logic run_status_indicator;
      logic error_status_indicator;
   } led_out_s;
endpackage : led_pkg

// ---- src/led_pattern_gen.sv ----
// shared millisecond time base and the blink, single and double flash patterns
// assumes core_clk at CLK_HZ; the parent passes the cycles per millisecond
`timescale 1ns/1ns
`default_nettype none
`include "led_map.svh"
module led_pattern_gen #(
   parameter int unsigned MS_CYCLES = `CLK_HZ / `MS_PER_S
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   output led_pkg::pattern_s pattern
);
   import led_pkg::*;
   localparam int MS_W = $clog2(MS_CYCLES);

   logic [MS_W-1:0] ms_cnt_r, ms_cnt_nxt;
   logic [`STEP_MS_W-1:0] step_ms_r, step_ms_nxt;
   logic [`STEP_W-1:0] s6_r, s6_nxt, s8_r, s8_nxt;
   logic blink_r, blink_nxt;
   pattern_s pat_r, pat_nxt;
   logic ms_tick, step_tick;

   ////////////////////////////////////////////////////////////////////////////
   // one step counter feeds every pattern so equal patterns stay in phase
   always_comb begin
      ms_tick = (ms_cnt_r == MS_W'(MS_CYCLES - 1));
      step_tick = ms_tick && (step_ms_r == `STEP_MS_W'(`FLASH_MS - 1)); // see [RL18]
      ms_cnt_nxt = ms_tick ? '0 : ms_cnt_r + 1'b1;
      step_ms_nxt = step_ms_r;
      s6_nxt = s6_r;
      s8_nxt = s8_r;
      blink_nxt = blink_r;
      if (ms_tick) begin
         step_ms_nxt = step_tick ? '0 : step_ms_r + 1'b1;
      end
      if (step_tick) begin
         blink_nxt = ~blink_r; // see [RL1]
         s6_nxt = (s6_r == `STEP_W'(`SINGLE_STEPS - 1)) ? '0 : s6_r + 1'b1;
         s8_nxt = (s8_r == `STEP_W'(`DOUBLE_STEPS - 1)) ? '0 : s8_r + 1'b1;
      end
      pat_nxt.blink = blink_nxt;
      pat_nxt.single = (s6_nxt == '0); // see [RL2]
      pat_nxt.dbl = (s8_nxt == '0) || (s8_nxt == `STEP_W'(2)); // see [RL3]
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ms_cnt_r <= '0;
         step_ms_r <= '0;
         s6_r <= '0;
         s8_r <= '0;
         blink_r <= 1'b1;
         pat_r <= '{blink: 1'b1, single: 1'b1, dbl: 1'b1};
      end else if (clk_en) begin
         ms_cnt_r <= ms_cnt_nxt;
         step_ms_r <= step_ms_nxt;
         s6_r <= s6_nxt;
         s8_r <= s8_nxt;
         blink_r <= blink_nxt;
         pat_r <= pat_nxt;
      end
   end

   assign pattern = pat_r;
endmodule : led_pattern_gen
`default_nettype wire

// ---- src/safety_status_led_driver.sv ----
// front-panel status indicator driver with an AHB-Lite register window
// assumes a single AHB-Lite master, word transfers, and discrete LEDs outside
//
// Operation
// [RL1] blinking: 200 ms on, 200 ms off, repeating, 2.5 Hz
// [RL2] single flash: 200 ms on, then 1000 ms off, repeating
// [RL3] double flash: two 200 ms pulses, 200 ms gap, 1000 ms off
// [RL4] run-status indicator off in fieldbus INIT state
// [RL5] run-status indicator blinks green in PRE-OPERATIONAL
// [RL6] run-status indicator single-flashes green in SAFE-OPERATIONAL
// [RL7] run-status indicator steady green in OPERATIONAL
// [RL8] error-status indicator off with no pending fieldbus error
// [RL9] error-status indicator blinks red on configuration error
// [RL10] error-status indicator single-flashes red after local state change
// [RL11] error-status indicator double-flashes red after application watchdog timeout
// [RL12] power-on test lights every indicator, safety outputs red
// [RL13] firmware loading: com and enable alternate quickly, others off, outputs red
// [RL14] com indicator on while configuration PC connected, else off
// [RL15] external fault lights its indicator; only the faulty input flashes
// [RL16] safety output: red off, green on, yellow restart, blinking yellow bad feedback
// [RL17] aux indicator mirrors output if status, input if feedback or restart
// [RL18] all patterns come from one shared millisecond time base
`timescale 1ns/1ns
`default_nettype none
`include "led_map.svh"
module safety_status_led_driver #(
   parameter int unsigned MS_CYCLES = `CLK_HZ / `MS_PER_S
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output led_pkg::led_out_s leds
);
   import led_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // decode shared by the write and read paths
   function automatic reg_sel_e reg_decode(input logic [31:0] a);
      reg_sel_e s;
      s = SEL_NONE;
      if (a[31:8] == 24'h00_0000) begin
         case (a[7:0])
            `ADDR_MODE: s = SEL_MODE;
            `ADDR_FBUS: s = SEL_FBUS;
            `ADDR_INPUTS: s = SEL_INPUTS;
            `ADDR_OUTPUTS: s = SEL_OUTPUTS;
            `ADDR_STATUS: s = SEL_STATUS;
            default: s = SEL_NONE;
         endcase
      end
      return s;
   endfunction : reg_decode

   // fieldbus indicator pattern; code 3 is steady for run, double flash for error
   function automatic logic fb_pattern(input logic [1:0] code, input pattern_s p,
                                       input logic is_err);
      logic v;
      v = 1'b0;
      case (code)
         2'h0: v = 1'b0;
         2'h1: v = p.blink;
         2'h2: v = p.single;
         2'h3: v = is_err ? p.dbl : 1'b1;
         default: v = 1'b0;
      endcase
      return v;
   endfunction : fb_pattern

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: writes take no wait state, reads take one
   logic [31:0] addr_r, addr_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic rd_wait_r, rd_wait_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic [31:0] mode_r, mode_nxt;
   logic [31:0] fbus_r, fbus_nxt;
   logic [31:0] inputs_r, inputs_nxt;
   logic [31:0] outputs_r, outputs_nxt;
   led_out_s led_r, led_nxt;
   logic accept;
   reg_sel_e wsel;

   always_comb begin
      accept = hsel && htrans[1] && hready && clk_en;
      wsel = reg_decode(addr_r);
      addr_nxt = accept ? haddr : addr_r;
      wr_pend_nxt = accept && hwrite;
      rd_wait_nxt = accept && !hwrite;
      hrdata_nxt = hrdata_r;
      mode_nxt = mode_r;
      fbus_nxt = fbus_r;
      inputs_nxt = inputs_r;
      outputs_nxt = outputs_r;
      if (wr_pend_r) begin
         case (wsel)
            SEL_MODE: mode_nxt = hwdata & `MODE_MASK;
            SEL_FBUS: fbus_nxt = hwdata & `FBUS_MASK;
            SEL_INPUTS: inputs_nxt = hwdata & `INPUTS_MASK;
            SEL_OUTPUTS: outputs_nxt = hwdata & `OUTPUTS_MASK;
            default: ;
         endcase
      end
      // the wait cycle lets a write just before the read land first
      if (rd_wait_r) begin
         case (wsel)
            SEL_MODE: hrdata_nxt = mode_r;
            SEL_FBUS: hrdata_nxt = fbus_r;
            SEL_INPUTS: hrdata_nxt = inputs_r;
            SEL_OUTPUTS: hrdata_nxt = outputs_r;
            SEL_STATUS: hrdata_nxt = 32'(led_r);
            default: hrdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         addr_r <= 32'h0000_0000;
         wr_pend_r <= 1'b0;
         rd_wait_r <= 1'b0;
         hrdata_r <= 32'h0000_0000;
         mode_r <= `REG_RST;
         fbus_r <= `REG_RST;
         inputs_r <= `REG_RST;
         outputs_r <= `REG_RST;
      end else if (clk_en) begin
         addr_r <= addr_nxt;
         wr_pend_r <= wr_pend_nxt;
         rd_wait_r <= rd_wait_nxt;
         hrdata_r <= hrdata_nxt;
         mode_r <= mode_nxt;
         fbus_r <= fbus_nxt;
         inputs_r <= inputs_nxt;
         outputs_r <= outputs_nxt;
      end
   end

   // stalling while frozen keeps a data phase from slipping past a held clock enable
   assign hreadyout = !rd_wait_r && clk_en;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // shared pattern source
   pattern_s pat;

   led_pattern_gen #(
      .MS_CYCLES(MS_CYCLES)
   ) u_pattern (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .pattern(pat) // see [RL18]
   );

   ////////////////////////////////////////////////////////////////////////////
   // per safety output colour and aux indicator
   logic [`N_OUTPUTS-1:0] so_red, so_green, aux_led;

   generate
      for (genvar i = 0; i < `N_OUTPUTS; i++) begin : g_out
         so_state_e st;
         assign st = so_state_e'(outputs_r[2*i +: 2]);
         // yellow is red and green lit together
         assign so_red[i] = (st == SO_OFF) || (st == SO_RESTART) ||
                            ((st == SO_FBK_BAD) && pat.blink); // see [RL16]
         assign so_green[i] = (st == SO_ON) || (st == SO_RESTART) ||
                              ((st == SO_FBK_BAD) && pat.blink); // see [RL16]
         assign aux_led[i] = outputs_r[`OUT_CFG_LSB + i] ? outputs_r[`OUT_AUX_LSB + i] :
                             (st == SO_ON); // see [RL17]
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // indicator composition by controller phase
   phase_e phase;
   logic ext_fault;
   logic [`N_INPUTS-1:0] in_cond, in_fault;

   always_comb begin
      phase = phase_e'(mode_r[`MODE_PHASE_MSB:`MODE_PHASE_LSB]);
      ext_fault = mode_r[`MODE_EXT_BIT];
      in_cond = inputs_r[`IN_COND_LSB +: `N_INPUTS];
      in_fault = inputs_r[`IN_FAULT_LSB +: `N_INPUTS];
      led_nxt = '0;
      case (phase)
         PH_TEST: begin
            led_nxt = '1; // see [RL12]
            led_nxt.safety_output_green = '0; // see [RL12]
         end
         PH_FW_LOAD: begin
            led_nxt.com_indicator = pat.blink; // see [RL13]
            led_nxt.enable_indicator = !pat.blink; // see [RL13]
            led_nxt.safety_output_red = '1; // see [RL13]
         end
         default: begin
            led_nxt.run_indicator = 1'b1;
            led_nxt.input_fail_indicator = 1'b0;
            led_nxt.external_fault_indicator = ext_fault; // see [RL15]
            led_nxt.com_indicator = mode_r[`MODE_PC_BIT]; // see [RL14]
            led_nxt.enable_indicator = 1'b1;
            // during a fault only the offending inputs show, and they flash
            led_nxt.input_indicators = ext_fault ? (in_fault & {`N_INPUTS{pat.blink}}) :
                                       in_cond; // see [RL15]
            led_nxt.safety_output_red = so_red;
            led_nxt.safety_output_green = so_green;
            led_nxt.aux_signal_indicators = aux_led;
            // codes map INIT/PREOP/SAFEOP/OP to off/blink/single/steady
            led_nxt.run_status_indicator = fb_pattern(fbus_r[`FBUS_RUN_MSB:`FBUS_RUN_LSB],
                                                      pat, 1'b0); // see [RL4] [RL5] [RL6] [RL7]
            // codes map none/config/local/watchdog to off/blink/single/double
            led_nxt.error_status_indicator = fb_pattern(fbus_r[`FBUS_ERR_MSB:`FBUS_ERR_LSB],
                                                        pat, 1'b1); // see [RL8] [RL9] [RL10] [RL11]
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         led_r <= '0;
      end else if (clk_en) begin
         led_r <= led_nxt;
      end
   end

   assign leds = led_r;
endmodule : safety_status_led_driver
`default_nettype wire

// ---- sim/led_panel.sv ----
// front-panel lamp model: measures on and off spans of the two fieldbus lamps
// assumes lamps are plain active-high levels sampled on core_clk
`timescale 1ns/1ns
`default_nettype none
module pulse_meter (
   input wire logic core_clk,
   input wire logic lamp,
   output logic [15:0] on_len,
   output logic [15:0] off_len,
   output logic [15:0] off_prev
);
   logic [15:0] span;
   logic last;
   initial begin
      span = 16'h0;
      last = 1'b0;
      on_len = 16'h0;
      off_len = 16'h0;
      off_prev = 16'h0;
   end
   // two off spans kept: the double flash alternates a short and a long gap
   always @(posedge core_clk) begin
      if (lamp !== last) begin
         if (last) on_len <= span;
         else begin
            off_prev <= off_len;
            off_len <= span;
         end
         span <= 16'h1;
      end else span <= span + 16'h1;
      last <= lamp;
   end
endmodule : pulse_meter
////////////////////////////////////////////////////////////////////////////////
module led_panel (
   input wire logic core_clk,
   input wire led_pkg::led_out_s leds,
   output logic [15:0] r_on,
   output logic [15:0] r_off,
   output logic [15:0] r_prev,
   output logic [15:0] e_on,
   output logic [15:0] e_off,
   output logic [15:0] e_prev
);
   pulse_meter run_m (.core_clk(core_clk), .lamp(leds.run_status_indicator), .on_len(r_on),
      .off_len(r_off), .off_prev(r_prev));
   pulse_meter err_m (.core_clk(core_clk), .lamp(leds.error_status_indicator), .on_len(e_on),
      .off_len(e_off), .off_prev(e_prev));
endmodule : led_panel
`default_nettype wire

// ---- sim/led_driver_chk.sv ----
// concurrent checks on the indicator driver ports
// assumes one clock domain and hready looped back from hreadyout
`timescale 1ns/1ns
`default_nettype none
module led_driver_chk #(
   parameter int unsigned MS_CYCLES = 20000
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire led_pkg::led_out_s leds
);
   import led_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   localparam int STEP = 200 * MS_CYCLES;
   logic [31:0] hi_cnt_r;
   logic [31:0] hi_cnt_nxt;
   // test phase lights the error lamp steadily, so it is not counted there
   always_comb begin
      hi_cnt_nxt = hi_cnt_r;
      if (clk_en) begin
         hi_cnt_nxt = 32'h0;
         if (leds.error_status_indicator && !leds.input_fail_indicator)
            hi_cnt_nxt = hi_cnt_r + 32'h1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) hi_cnt_r <= 32'h0;
      else hi_cnt_r <= hi_cnt_nxt;
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence rd_taken;
      hsel && htrans[1] && hready && clk_en && !hwrite;
   endsequence
   sequence wr_taken;
      hsel && htrans[1] && hready && clk_en && hwrite;
   endsequence
   sequence rd_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   a_read_wait: assert property (rd_taken |=> rd_answer) else $error("read answer late");
   a_write_nowait: assert property (wr_taken |=> hreadyout) else $error("write stalled");
   a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
   a_stall_low: assert property (!clk_en |-> !hreadyout) else $error("ready while stalled");
   a_test_lamps: assert property ($rose(rst_n) && clk_en |=> leds == 27'h7FF_FC3F)
      else $error("test pattern wrong");
   a_test_red: assert property (leds.input_fail_indicator |->
      leds.safety_output_green == 4'h0 && leds.com_indicator && leds.enable_indicator)
      else $error("test lamps wrong");
   a_fw_alternate: assert property (!leds.run_indicator && (leds.com_indicator
      || leds.enable_indicator) |-> leds.com_indicator != leds.enable_indicator
      && leds.safety_output_red == 4'hF && leds.input_indicators == 8'h00)
      else $error("loading lamps wrong");
   a_err_flash_len: assert property (hi_cnt_r <= STEP)
      else $error("error lamp on too long");
endmodule : led_driver_chk
bind safety_status_led_driver led_driver_chk #(.MS_CYCLES(MS_CYCLES)) chk (
   .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .leds(leds));
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench: AHB-Lite register writes, lamp levels and flash spans
// assumes the lamp model measures spans; MS_CYCLES shrunk to 2
`timescale 1ns/1ns
`default_nettype none
`include "led_map.svh"
module tb;
   import led_pkg::*;
   localparam int unsigned MSC = 2;
   localparam int STEP = 200 * MSC;
   logic core_clk, rst_n, clk_en, hsel, hwrite, hreadyout, hresp, v;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] r_on, r_off, r_prev, e_on, e_off, e_prev;
   led_out_s leds;
   int errors, check_count;
   int sums[4] = '{0, 2 * STEP, 10 * STEP, 6 * STEP};
   safety_status_led_driver #(.MS_CYCLES(MSC)) DUT (.core_clk(core_clk), .rst_n(rst_n),
      .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .leds(leds));
   led_panel panel (.core_clk(core_clk), .leds(leds), .r_on(r_on), .r_off(r_off),
      .r_prev(r_prev), .e_on(e_on), .e_off(e_off), .e_prev(e_prev));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // ready is looked at on the falling edge, where it has settled
   task automatic wait_rdy(output logic [31:0] q);
      logic r;
      r = 1'b0;
      while (r !== 1'b1) begin
         @(negedge core_clk);
         r = hreadyout;
         q = hrdata;
         @(posedge core_clk);
      end
   endtask : wait_rdy
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      wait_rdy(rd);
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy(rd);
      repeat (2) @(negedge core_clk);
   endtask : bus
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      repeat (60000) @(posedge core_clk);
      errors++;
      summarize();
   end
   initial begin
      {errors, check_count, rst_n, hsel, haddr, htrans, hwrite, hwdata} = '0;
      clk_en = 1'b1;
      hsize = 3'h2;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2) @(negedge core_clk);
      check("test", 32'h07FF_FC3F, 32'(leds));
      bus(1'b0, `ADDR_STATUS, 32'h0);
      check("status", 32'h07FF_FC3F, rd);
      bus(1'b0, `ADDR_MODE, 32'h0);
      check("mode rst", `REG_RST, rd);
      bus(1'b1, `ADDR_MODE, 32'h1);
      v = leds.com_indicator;
      check("load", {!v, 4'hF, 4'h0},
         {leds.enable_indicator, leds.safety_output_red, leds.safety_output_green});
      repeat (STEP) @(negedge core_clk);
      check("load com", !v, leds.com_indicator);
      bus(1'b1, `ADDR_FBUS, 32'hFFFF_FFFF);
      bus(1'b0, `ADDR_FBUS, 32'h0);
      check("fbus rd", `FBUS_MASK, rd);
      bus(1'b1, 32'h20, 32'hFFFF_FFFF);
      bus(1'b0, 32'h20, 32'h0);
      check("unmapped", 32'h0, rd);
      bus(1'b1, `ADDR_MODE, 32'h12);
      check("pc on", 3'b111,
         {leds.run_indicator, leds.com_indicator, leds.enable_indicator});
      bus(1'b1, `ADDR_MODE, 32'h02);
      check("pc off", 1'b0, leds.com_indicator);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, `ADDR_FBUS, (i << 4) | i);
         repeat (18 * STEP) @(negedge core_clk);
         if (i == 0) check("fb idle", 2'b00,
            {leds.run_status_indicator, leds.error_status_indicator});
         else check("err span", (STEP << 16) | sums[i],
            {e_on, 16'(e_off + e_prev)});
         if (i == 1 || i == 2) check("run span", (STEP << 16) | sums[i],
            {r_on, 16'(r_off + r_prev)});
         if (i == 1 || i == 2) check("phase", leds.error_status_indicator,
            leds.run_status_indicator);
         if (i == 3) check("run op", 1'b1, leds.run_status_indicator);
      end
      bus(1'b1, `ADDR_OUTPUTS, 32'h0000_ACE4);
      check("outputs", 10'b101_110_1010, {leds.safety_output_red[2:0],
         leds.safety_output_green[2:0], leds.aux_signal_indicators});
      v = leds.safety_output_red[3];
      check("fbk yel", v, leds.safety_output_green[3]);
      repeat (STEP) @(negedge core_clk);
      check("fbk blink", !v, leds.safety_output_red[3]);
      bus(1'b1, `ADDR_INPUTS, 32'h0000_815A);
      check("inputs", 9'h05A,
         {leds.external_fault_indicator, leds.input_indicators});
      bus(1'b1, `ADDR_MODE, 32'h22);
      v = leds.input_indicators[0];
      check("ext flt", {1'b1, v, 6'h0, v},
         {leds.external_fault_indicator, leds.input_indicators});
      repeat (STEP) @(negedge core_clk);
      check("ext blink", {!v, 6'h0, !v}, leds.input_indicators);
      // a full step frozen: the flashing inputs would have changed if anything ran
      @(posedge core_clk);
      clk_en <= 1'b0;
      @(negedge core_clk);
      rd = 32'(leds);
      repeat (STEP) @(negedge core_clk);
      check("stall", 1'b0, hreadyout);
      check("frozen", rd, 32'(leds));
      check("resp", 1'b0, hresp);
      @(posedge core_clk);
      clk_en <= 1'b1;
      repeat (2) @(negedge core_clk);
      check("resume", 1'b1, hreadyout);
      summarize();
   end
endmodule : tb
`default_nettype wire
